// File: mtd_det_if.sv
// detector configuration path between register bank and latches
`timescale 1ns/1ps
`default_nettype none
interface mtd_det_if;
  logic        load;
  logic [15:0] ctrl;
  logic [15:0] th1;
  logic [15:0] th2;
  logic [15:0] th3;
  logic [15:0] lat_ctrl;
  logic [15:0] lat_th1;
  logic [15:0] lat_th2;
  logic [15:0] lat_th3;

  modport bank (
    output load,
    output ctrl,
    output th1,
    output th2,
    output th3,
    input  lat_ctrl,
    input  lat_th1,
    input  lat_th2,
    input  lat_th3
  );

  modport latch (
    input  load,
    input  ctrl,
    input  th1,
    input  th2,
    input  th3,
    output lat_ctrl,
    output lat_th1,
    output lat_th2,
    output lat_th3
  );
endinterface
`default_nettype wire

// File: mtd_det_latch.sv
// reset-immune detector configuration latches
`timescale 1ns/1ps
`default_nettype none
module mtd_det_latch (
  input  wire logic clk_sys,
  mtd_det_if.latch  cfg
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] th1;
    logic [15:0] th2;
    logic [15:0] th3;
  } mtd_latch_s;

  mtd_latch_s lat_q;
  mtd_latch_s lat_d;

  // all four captured together on any load
  always_comb begin
    lat_d = lat_q;
    if (cfg.load) begin
      lat_d.ctrl = cfg.ctrl;
      lat_d.th1  = cfg.th1;
      lat_d.th2  = cfg.th2;
      lat_d.th3  = cfg.th3;
    end
  end

  // no reset and no power-mode input: contents kept until next load
  always_ff @(posedge clk_sys) begin
    lat_q <= lat_d;
  end

  assign cfg.lat_ctrl = lat_q.ctrl;
  assign cfg.lat_th1  = lat_q.th1;
  assign cfg.lat_th2  = lat_q.th2;
  assign cfg.lat_th3  = lat_q.th3;

endmodule
`default_nettype wire

// File: mtd_host_model.sv
// spi host model that sends header and data frames
`timescale 1ns/1ps
`default_nettype none
module mtd_host_model #(parameter int HALF = 4) (
  input  wire logic clk_sys,
  output var  logic spi_sclk,
  output var  logic spi_cs_n,
  output var  logic spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // msb first, mosi moves on falling sclk, miso taken on rising sclk
  task automatic xfer(input logic rw, input logic [9:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    logic [31:0] sh;
    sh = {rw, 5'h00, a, d};
    q = 16'h0000;
    @(posedge clk_sys);
    spi_cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk_sys);
      spi_sclk <= 1'b0;
      spi_mosi <= sh[i];
      repeat (HALF) @(posedge clk_sys);
      spi_sclk <= 1'b1;
      q = {q[14:0], spi_miso};
      repeat (HALF - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;
    repeat (2 * HALF) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: mtd_pkg.sv
// constants shared by the threshold register bank and its testbench
package mtd_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned CNT_W  = 6;

  // spi frame: header word then data word, msb first
  localparam int unsigned HDR_READ_BIT = 15;
  localparam logic [CNT_W-1:0] BITS_HDR   = 6'h10;
  localparam logic [CNT_W-1:0] BITS_FRAME = 6'h20;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 10'h002;
  localparam logic [ADDR_W-1:0] ADDR_FUNC_EN    = 10'h004;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_LOSS = 10'h009;
  localparam logic [ADDR_W-1:0] ADDR_NEUTRAL_TH = 10'h00a;
  localparam logic [ADDR_W-1:0] ADDR_VTHD_TH    = 10'h00c;
  localparam logic [ADDR_W-1:0] ADDR_ITHD_TH    = 10'h00d;
  localparam logic [ADDR_W-1:0] ADDR_LOG        = 10'h00f;
  localparam logic [ADDR_W-1:0] ADDR_DET_CTRL   = 10'h010;
  localparam logic [ADDR_W-1:0] ADDR_DET_TH1    = 10'h011;
  localparam logic [ADDR_W-1:0] ADDR_DET_TH2    = 10'h012;
  localparam logic [ADDR_W-1:0] ADDR_DET_TH3    = 10'h013;

  // reset values
  localparam logic [DATA_W-1:0] RST_ZERO      = 16'h0000;
  localparam logic [DATA_W-1:0] RST_WARN_TH   = 16'h00ff;

  // second status / first function enable bit positions
  localparam int unsigned NEUTRAL_OV_BIT = 14;
  localparam int unsigned VTHD_OV_BIT    = 11;
  localparam int unsigned ITHD_OV_BIT    = 10;

  // writable bit masks
  localparam logic [DATA_W-1:0] FLAG_MASK     = 16'h4c00;
  localparam logic [DATA_W-1:0] DET_CTRL_MASK = 16'h003f;
  localparam logic [DATA_W-1:0] DET_TH_MASK   = 16'h7f7f;

endpackage

// File: mtd_properties.sv
// assertion checker for the threshold register bank
`timescale 1ns/1ps
`default_nettype none
module mtd_properties (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        spi_cs_n,
  input wire logic        spi_miso_oe,
  input wire logic        warn_irq_q,
  input wire logic [15:0] phase_loss_threshold_q,
  input wire logic [15:0] neutral_overcurrent_threshold_q,
  input wire logic [15:0] voltage_distortion_threshold_q,
  input wire logic [15:0] current_distortion_threshold_q,
  input wire logic [15:0] second_system_status_q,
  input wire logic [5:0]  det_powerdown_q,
  input wire logic [15:0] det_th1_q
);
  // set once reset has been released at least once
  logic live_q = 1'b0;
  always_ff @(posedge clk_sys) live_q <= live_q | ~srst;
  default clocking dc @(posedge clk_sys); endclocking
  plt_reset_a: assert property (srst |=> phase_loss_threshold_q == 16'h0000)
    else $error("phase loss threshold not cleared");
  nth_reset_a: assert property (srst |=> neutral_overcurrent_threshold_q == 16'h00ff)
    else $error("neutral threshold not at default");
  vth_reset_a: assert property (srst |=> voltage_distortion_threshold_q == 16'h00ff)
    else $error("voltage distortion threshold not at default");
  ith_reset_a: assert property (srst |=> current_distortion_threshold_q == 16'h00ff)
    else $error("current distortion threshold not at default");
  det_keep_a: assert property (live_q && srst |=> $stable(det_powerdown_q) && $stable(det_th1_q))
    else $error("detector latch disturbed by reset");
  irq_idle_a: assert property (srst |=> !warn_irq_q)
    else $error("warning interrupt set after reset");
  th_hold_a: assert property (disable iff (srst) spi_cs_n [*8] |->
    $stable(phase_loss_threshold_q) && $stable(neutral_overcurrent_threshold_q))
    else $error("threshold changed outside a frame");
  oe_idle_a: assert property (disable iff (srst) spi_cs_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  frame_c: cover property ($fell(spi_cs_n));
  flag_c: cover property ($rose(second_system_status_q[14]));
  irq_c: cover property ($rose(warn_irq_q));
endmodule
bind mtd_regs mtd_properties chk_i (.clk_sys(clk_sys), .srst(srst), .spi_cs_n(spi_cs_n),
  .spi_miso_oe(spi_miso_oe), .warn_irq_q(warn_irq_q), .det_th1_q(det_th1_q),
  .phase_loss_threshold_q(phase_loss_threshold_q), .det_powerdown_q(det_powerdown_q),
  .neutral_overcurrent_threshold_q(neutral_overcurrent_threshold_q),
  .voltage_distortion_threshold_q(voltage_distortion_threshold_q),
  .current_distortion_threshold_q(current_distortion_threshold_q),
  .second_system_status_q(second_system_status_q));
`default_nettype wire

// File: mtd_regs.sv
// threshold and detector register bank behind the spi slave
`timescale 1ns/1ps
`default_nettype none
module mtd_regs (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output var  logic        spi_miso_o,
  output var  logic        spi_miso_oe,
  input  wire logic        meas_valid,
  input  wire logic [15:0] neutral_rms_ma,
  input  wire logic [15:0] voltage_thd,
  input  wire logic [15:0] current_thd,
  output var  logic [15:0] phase_loss_threshold_q,
  output var  logic [15:0] neutral_overcurrent_threshold_q,
  output var  logic [15:0] voltage_distortion_threshold_q,
  output var  logic [15:0] current_distortion_threshold_q,
  output var  logic [15:0] second_system_status_q,
  output var  logic        warn_irq_q,
  output var  logic [5:0]  det_powerdown_q,
  output var  logic [15:0] det_th1_q,
  output var  logic [15:0] det_th2_q,
  output var  logic [15:0] det_th3_q
);

  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [1:0]  mosi_s;
    logic [5:0]  cnt;
    logic [mtd_pkg::ADDR_W-1:0] addr;
    logic [15:0] rx;
    logic [15:0] tx;
    logic        rd;
    logic [15:0] rd_word;
    logic        miso;
    logic        miso_oe;
    logic [15:0] status;
    logic [15:0] func_en;
    logic [15:0] phase_loss;
    logic [15:0] neutral_th;
    logic [15:0] vthd_th;
    logic [15:0] ithd_th;
    logic [15:0] xfer_log;
    logic [15:0] det_ctrl;
    logic [15:0] det_th1;
    logic [15:0] det_th2;
    logic [15:0] det_th3;
    logic        load;
    logic        irq;
  } mtd_bank_s;

  mtd_bank_s st_q;
  mtd_bank_s st_d;

  mtd_det_if det_cfg ();

  mtd_det_latch u_det_latch (
    .clk_sys (clk_sys),
    .cfg     (det_cfg.latch)
  );

  // reset image of the bank; spi pins idle with chip select high
  function automatic mtd_bank_s rst_state();
    mtd_bank_s r;
    r            = '0;
    r.cs_s       = 3'h7;
    r.sclk_s     = 3'h7;
    r.status     = mtd_pkg::RST_ZERO;
    r.func_en    = mtd_pkg::RST_ZERO;
    r.phase_loss = mtd_pkg::RST_ZERO;
    r.neutral_th = mtd_pkg::RST_WARN_TH;
    r.vthd_th    = mtd_pkg::RST_WARN_TH;
    r.ithd_th    = mtd_pkg::RST_WARN_TH;
    r.xfer_log   = mtd_pkg::RST_ZERO;
    r.det_ctrl   = mtd_pkg::RST_ZERO;
    r.det_th1    = mtd_pkg::RST_ZERO;
    r.det_th2    = mtd_pkg::RST_ZERO;
    r.det_th3    = mtd_pkg::RST_ZERO;
    return r;
  endfunction

  // read data for an address, unmapped reads as zero
  function automatic logic [15:0] read_mux(
    input mtd_bank_s                      s,
    input logic [mtd_pkg::ADDR_W-1:0]     a
  );
    logic [15:0] v;
    v = mtd_pkg::RST_ZERO;
    if (a == mtd_pkg::ADDR_STATUS) begin
      v = s.status;
    end else if (a == mtd_pkg::ADDR_FUNC_EN) begin
      v = s.func_en;
    end else if (a == mtd_pkg::ADDR_PHASE_LOSS) begin
      v = s.phase_loss;
    end else if (a == mtd_pkg::ADDR_NEUTRAL_TH) begin
      v = s.neutral_th;
    end else if (a == mtd_pkg::ADDR_VTHD_TH) begin
      v = s.vthd_th;
    end else if (a == mtd_pkg::ADDR_ITHD_TH) begin
      v = s.ithd_th;
    end else if (a == mtd_pkg::ADDR_LOG) begin
      v = s.xfer_log;
    end else if (a == mtd_pkg::ADDR_DET_CTRL) begin
      v = s.det_ctrl & mtd_pkg::DET_CTRL_MASK;
    end else if (a == mtd_pkg::ADDR_DET_TH1) begin
      v = s.det_th1;
    end else if (a == mtd_pkg::ADDR_DET_TH2) begin
      v = s.det_th2;
    end else if (a == mtd_pkg::ADDR_DET_TH3) begin
      v = s.det_th3;
    end
    return v;
  endfunction

  // pin sample shifted into a three-stage synchroniser
  function automatic logic [2:0] sync_shift(
    input logic [2:0] s,
    input logic       pin
  );
    return {s[1:0], pin};
  endfunction

  // edge seen between the second and third synchroniser stage
  function automatic logic edge_seen(
    input logic [2:0] s,
    input logic       rising
  );
    return rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
  endfunction

  // one warning: fresh result above its threshold with the function enabled
  function automatic logic over_th(
    input logic        valid,
    input logic [15:0] value,
    input logic [15:0] th,
    input logic        en
  );
    return valid & en & (value > th);
  endfunction

  // flags keep only their own bits; a set beats a same-cycle clear
  function automatic logic [15:0] next_status(
    input logic [15:0] cur,
    input logic [15:0] clr_bits,
    input logic [15:0] set_bits
  );
    return ((cur & ~clr_bits) | set_bits) & mtd_pkg::FLAG_MASK;
  endfunction

  // any of the four detector registers
  function automatic logic is_det_addr(
    input logic [mtd_pkg::ADDR_W-1:0] a
  );
    return (a == mtd_pkg::ADDR_DET_CTRL)
        || (a == mtd_pkg::ADDR_DET_TH1)
        || (a == mtd_pkg::ADDR_DET_TH2)
        || (a == mtd_pkg::ADDR_DET_TH3);
  endfunction

  // register write; reserved detector bits dropped on the way in
  function automatic mtd_bank_s apply_write(
    input mtd_bank_s                  s,
    input logic [mtd_pkg::ADDR_W-1:0] a,
    input logic [15:0]                d
  );
    mtd_bank_s n;
    n = s;
    if (a == mtd_pkg::ADDR_FUNC_EN) begin
      n.func_en = d;
    end else if (a == mtd_pkg::ADDR_PHASE_LOSS) begin
      n.phase_loss = d;
    end else if (a == mtd_pkg::ADDR_NEUTRAL_TH) begin
      n.neutral_th = d;
    end else if (a == mtd_pkg::ADDR_VTHD_TH) begin
      n.vthd_th = d;
    end else if (a == mtd_pkg::ADDR_ITHD_TH) begin
      n.ithd_th = d;
    end else if (a == mtd_pkg::ADDR_DET_CTRL) begin
      n.det_ctrl = d & mtd_pkg::DET_CTRL_MASK;
    end else if (a == mtd_pkg::ADDR_DET_TH1) begin
      n.det_th1 = d & mtd_pkg::DET_TH_MASK;
    end else if (a == mtd_pkg::ADDR_DET_TH2) begin
      n.det_th2 = d & mtd_pkg::DET_TH_MASK;
    end else if (a == mtd_pkg::ADDR_DET_TH3) begin
      n.det_th3 = d & mtd_pkg::DET_TH_MASK;
    end
    n.load = is_det_addr(a);
    return n;
  endfunction

  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      cs_active;
  logic                      mosi_bit;
  logic [15:0]               rx_next;
  logic [mtd_pkg::ADDR_W-1:0] wr_addr;
  logic                      wr_en;
  logic [15:0]               wr_data;
  logic [15:0]               flag_clr;
  logic [15:0]               flag_set;
  logic                      neutral_over;
  logic                      vthd_over;
  logic                      ithd_over;

  always_comb begin
    st_d      = st_q;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_active = 1'b0;
    mosi_bit  = 1'b0;
    rx_next   = '0;
    wr_addr   = '0;
    wr_en     = 1'b0;
    wr_data   = '0;
    flag_clr  = '0;
    flag_set  = '0;
    neutral_over = 1'b0;
    vthd_over    = 1'b0;
    ithd_over    = 1'b0;

    // pin synchronisers, first stage read only by the second
    st_d.sclk_s = sync_shift(st_q.sclk_s, spi_sclk);
    st_d.cs_s   = sync_shift(st_q.cs_s, spi_cs_n);
    st_d.mosi_s = {st_q.mosi_s[0], spi_mosi};
    sclk_rise   = edge_seen(st_q.sclk_s, 1'b1);
    sclk_fall   = edge_seen(st_q.sclk_s, 1'b0);
    cs_active   = ~st_q.cs_s[1];
    mosi_bit    = st_q.mosi_s[1];
    st_d.load   = 1'b0;
    st_d.miso_oe = cs_active;

    // spi frame engine
    if (!cs_active) begin
      st_d.cnt  = '0;
      st_d.miso = 1'b0;
    end else if (sclk_rise && (st_q.cnt < mtd_pkg::BITS_FRAME)) begin
      rx_next  = {st_q.rx[14:0], mosi_bit};
      st_d.rx  = rx_next;
      st_d.cnt = st_q.cnt + 6'h01;
      if (st_q.cnt == (mtd_pkg::BITS_HDR - 6'h01)) begin
        st_d.rd      = rx_next[mtd_pkg::HDR_READ_BIT];
        st_d.rd_word = read_mux(st_q, rx_next[mtd_pkg::ADDR_W-1:0]);
        st_d.tx      = st_d.rd_word;
        wr_addr      = rx_next[mtd_pkg::ADDR_W-1:0];
        st_d.addr    = wr_addr;
      end
      if (st_q.cnt == (mtd_pkg::BITS_FRAME - 6'h01)) begin
        if (st_q.rd) begin
          st_d.xfer_log = st_q.rd_word;
        end else begin
          st_d.xfer_log = rx_next;
          wr_en         = 1'b1;
          wr_data       = rx_next;
        end
      end
    end else if (sclk_fall && st_q.rd && (st_q.cnt >= mtd_pkg::BITS_HDR)
                 && (st_q.cnt < mtd_pkg::BITS_FRAME)) begin
      st_d.miso = st_q.tx[15];
      st_d.tx   = {st_q.tx[14:0], 1'b0};
    end

    // register writes land on the last data bit, header address kept
    if (wr_en) begin
      wr_addr = st_q.addr;
      st_d    = apply_write(st_d, wr_addr, wr_data);
      if (wr_addr == mtd_pkg::ADDR_STATUS) begin
        flag_clr = wr_data & mtd_pkg::FLAG_MASK;
      end
    end

    // warning flags from the metering results
    neutral_over = over_th(meas_valid, neutral_rms_ma, st_q.neutral_th,
                           st_q.func_en[mtd_pkg::NEUTRAL_OV_BIT]);
    vthd_over    = over_th(meas_valid, voltage_thd, st_q.vthd_th,
                           st_q.func_en[mtd_pkg::VTHD_OV_BIT]);
    ithd_over    = over_th(meas_valid, current_thd, st_q.ithd_th,
                           st_q.func_en[mtd_pkg::ITHD_OV_BIT]);
    flag_set[mtd_pkg::NEUTRAL_OV_BIT] = neutral_over;
    flag_set[mtd_pkg::VTHD_OV_BIT]    = vthd_over;
    flag_set[mtd_pkg::ITHD_OV_BIT]    = ithd_over;
    st_d.status = next_status(st_q.status, flag_clr, flag_set);

    // interrupt needs the flag and its enable bit
    st_d.irq = |(st_d.status & st_d.func_en & mtd_pkg::FLAG_MASK);
  end

  // synchronous reset; the detector latches sit outside and never see it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= rst_state();
    end else begin
      st_q <= st_d;
    end
  end

  // spi data pin and its enable
  assign spi_miso_o  = st_q.miso;
  assign spi_miso_oe = st_q.miso_oe;

  // thresholds, status and interrupt
  assign phase_loss_threshold_q          = st_q.phase_loss;
  assign neutral_overcurrent_threshold_q = st_q.neutral_th;
  assign voltage_distortion_threshold_q  = st_q.vthd_th;
  assign current_distortion_threshold_q  = st_q.ithd_th;
  assign second_system_status_q          = st_q.status;
  assign warn_irq_q                      = st_q.irq;

  // bank copy towards the latches, taken one cycle after the write
  assign det_cfg.load = st_q.load;
  assign det_cfg.ctrl = st_q.det_ctrl;
  assign det_cfg.th1  = st_q.det_th1;
  assign det_cfg.th2  = st_q.det_th2;
  assign det_cfg.th3  = st_q.det_th3;

  // detector outputs show the latches, not the bank
  assign det_powerdown_q = det_cfg.lat_ctrl[$bits(det_powerdown_q)-1:0];
  assign det_th1_q       = det_cfg.lat_th1;
  assign det_th2_q       = det_cfg.lat_th2;
  assign det_th3_q       = det_cfg.lat_th3;

endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the threshold register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        mv = 1'b0;
  logic [15:0] nrm = 16'h0000;
  logic [15:0] vtd = 16'h0000;
  logic [15:0] ctd = 16'h0000;
  wire logic   sclk, cs_n, mosi;
  logic        mo, moe, irq;
  logic [15:0] plt, nth, vth, ith, sts, th1, th2, th3, rd, r;
  logic [15:0] v[4], dv[4];
  logic [5:0]  pd;
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [9:0]  ta[4] = '{mtd_pkg::ADDR_PHASE_LOSS, mtd_pkg::ADDR_NEUTRAL_TH,
                         mtd_pkg::ADDR_VTHD_TH, mtd_pkg::ADDR_ITHD_TH};
  logic [15:0] tr[4] = '{mtd_pkg::RST_ZERO, mtd_pkg::RST_WARN_TH,
                         mtd_pkg::RST_WARN_TH, mtd_pkg::RST_WARN_TH};
  always #20 clk_sys = ~clk_sys;
  mtd_host_model host (.clk_sys(clk_sys), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(moe ? mo : cyc[0]));
  mtd_regs DUT (.clk_sys(clk_sys), .srst(srst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso_o(mo), .spi_miso_oe(moe), .meas_valid(mv),
    .neutral_rms_ma(nrm), .voltage_thd(vtd), .current_thd(ctd),
    .phase_loss_threshold_q(plt), .neutral_overcurrent_threshold_q(nth),
    .voltage_distortion_threshold_q(vth), .current_distortion_threshold_q(ith),
    .second_system_status_q(sts), .warn_irq_q(irq), .det_powerdown_q(pd),
    .det_th1_q(th1), .det_th2_q(th2), .det_th3_q(th3));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors = num_errors + 1;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] rnd();
    return 16'($urandom % 32'h0000_fff0);
  endfunction
  function automatic logic [15:0] flags(input logic over);
    return over ? mtd_pkg::FLAG_MASK : 16'h0000;
  endfunction
  task automatic meas(input logic [15:0] x);
    @(posedge clk_sys);
    nrm <= x;
    vtd <= x;
    ctd <= x;
    mv <= 1'b1;
    @(posedge clk_sys);
    mv <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    r = 16'($urandom(33));
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, ta[i], 16'h0000, rd);
      chk("threshold reset", rd, tr[i]);
      v[i] = rnd();
      host.xfer(1'b0, ta[i], v[i], rd);
      host.xfer(1'b1, ta[i], 16'h0000, rd);
      chk("threshold readback", rd, v[i]);
    end
    chk("phase loss port", plt, v[0]);
    chk("neutral port", nth, v[1]);
    chk("voltage port", vth, v[2]);
    chk("current port", ith, v[3]);
    host.xfer(1'b1, mtd_pkg::ADDR_LOG, 16'h0000, rd);
    chk("log after read", rd, v[3]);
    host.xfer(1'b1, mtd_pkg::ADDR_LOG, 16'h0000, rd);
    chk("log after log read", rd, v[3]);
    $display("test thresholds and log done");
    for (int i = 0; i < 4; i++) dv[i] = rnd();
    host.xfer(1'b0, mtd_pkg::ADDR_DET_CTRL, dv[0], rd);
    chk("powerdown", {10'h000, pd}, dv[0] & mtd_pkg::DET_CTRL_MASK);
    chk("unwritten th2 latched", th2, 16'h0000);
    chk("unwritten th1 latched", th1, 16'h0000);
    host.xfer(1'b1, mtd_pkg::ADDR_DET_CTRL, 16'h0000, rd);
    chk("ctrl readback", rd, dv[0] & mtd_pkg::DET_CTRL_MASK);
    host.xfer(1'b0, mtd_pkg::ADDR_DET_TH3, dv[3], rd);
    chk("th3 latch", th3, dv[3] & mtd_pkg::DET_TH_MASK);
    host.xfer(1'b1, mtd_pkg::ADDR_LOG, 16'h0000, rd);
    chk("log after write", rd, dv[3]);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    chk("powerdown kept", {10'h000, pd}, dv[0] & mtd_pkg::DET_CTRL_MASK);
    chk("th3 kept", th3, dv[3] & mtd_pkg::DET_TH_MASK);
    $display("test detector latches done");
    r = rnd();
    for (int i = 1; i < 4; i++) host.xfer(1'b0, ta[i], r, rd);
    host.xfer(1'b0, mtd_pkg::ADDR_FUNC_EN, mtd_pkg::FLAG_MASK, rd);
    meas(r);
    chk("flags at threshold", sts & mtd_pkg::FLAG_MASK, flags(1'b0));
    meas(r + 16'h0001);
    chk("flags above", sts & mtd_pkg::FLAG_MASK, flags(1'b1));
    chk("current flag", {15'h0000, sts[mtd_pkg::ITHD_OV_BIT]}, 16'h0001);
    chk("warning interrupt", {15'h0000, irq}, 16'h0001);
    host.xfer(1'b0, mtd_pkg::ADDR_STATUS, mtd_pkg::FLAG_MASK, rd);
    chk("flags cleared", sts & mtd_pkg::FLAG_MASK, flags(1'b0));
    chk("interrupt cleared", {15'h0000, irq}, 16'h0000);
    $display("test flags done");
    close_out();
  end
endmodule
`default_nettype wire
